// File: inc/ebr_pkg.sv
// Constants, types and register map of the embedded block RAM.
// Assumes a single system clock; all users write ebr_pkg::name.
package ebr_pkg;

    typedef enum logic [2:0] {
        MODE_SINGLE = 3'h0,
        MODE_TRUE_DUAL = 3'h1,
        MODE_PSEUDO_DUAL = 3'h2,
        MODE_ROM = 3'h3,
        MODE_FIFO = 3'h4
    } mode_t;

    typedef enum logic [2:0] {
        W_X1 = 3'h0,
        W_X2 = 3'h1,
        W_X4 = 3'h2,
        W_X9 = 3'h3,
        W_X18 = 3'h4,
        W_X36 = 3'h5
    } width_t;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 36;
    localparam int WORD_AW = 9;
    localparam int MEM_WORDS = 512;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int CNT_W = 15;
    localparam int WB_AW = 8;

    // Depth in words for each port width.
    localparam logic [14:0] DEPTH_X1 = 15'h4000;
    localparam logic [14:0] DEPTH_X2 = 15'h2000;
    localparam logic [14:0] DEPTH_X4 = 15'h1000;
    localparam logic [14:0] DEPTH_X9 = 15'h0800;
    localparam logic [14:0] DEPTH_X18 = 15'h0400;
    localparam logic [14:0] DEPTH_X36 = 15'h0200;

    // Register byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WIDTH = 8'h04;
    localparam logic [7:0] REG_AFULL = 8'h08;
    localparam logic [7:0] REG_AEMPTY = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_INIT_ADDR = 8'h14;
    localparam logic [7:0] REG_INIT_LO = 8'h18;
    localparam logic [7:0] REG_INIT_HI = 8'h1C;

    // Field positions.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OUTREG_A_BIT = 3;
    localparam int CTRL_OUTREG_B_BIT = 4;
    localparam int CTRL_SYNC_RST_BIT = 5;
    localparam int CTRL_CFG_DONE_BIT = 6;
    localparam int WIDTH_A_LSB = 0;
    localparam int WIDTH_B_LSB = 4;
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_AFULL_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;
    localparam int STAT_AEMPTY_BIT = 3;
    localparam int STAT_COUNT_LSB = 16;

    // Reset values.
    localparam logic [14:0] AFULL_RESET = 15'h01F8;
    localparam logic [14:0] AEMPTY_RESET = 15'h0008;
    localparam width_t WIDTH_A_RESET = W_X36;
    localparam width_t WIDTH_B_RESET = W_X36;

endpackage

// File: design/ebr_array.sv
// Storage array of 512 words of 36 bits with two synchronous ports.
// Assumes both ports run on sys_clk; on a same-word double write port B wins.
`timescale 1ns/1ps
`default_nettype none
module ebr_array (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Port A
    input wire logic en_a,
    input wire logic [35:0] wmask_a,
    input wire logic [8:0] addr_a,
    input wire logic [35:0] wdata_a,
    output logic [35:0] rdata_a,
    // Port B
    input wire logic en_b,
    input wire logic [35:0] wmask_b,
    input wire logic [8:0] addr_b,
    input wire logic [35:0] wdata_b,
    output logic [35:0] rdata_b
);
    logic [35:0] mem [0:ebr_pkg::MEM_WORDS-1];

    // Bit-wise write masks let narrow ports update part of a word in place.
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < ebr_pkg::DATA_W; i++) begin
            if (en_a && wmask_a[i]) begin
                mem[addr_a][i] <= wdata_a[i];
            end
            if (en_b && wmask_b[i]) begin
                mem[addr_b][i] <= wdata_b[i];
            end
        end
    end

    // Read before write: the old word is returned on a write cycle.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_a <= 36'h0;
            rdata_b <= 36'h0;
        end else begin
            if (en_a) begin
                rdata_a <= mem[addr_a];
            end
            if (en_b) begin
                rdata_b <= mem[addr_b];
            end
        end
    end
endmodule // ebr_array
`default_nettype wire

// File: design/embedded_block_ram.sv
// Embedded block RAM: two user ports, RAM/ROM/FIFO modes, Wishbone setup.
// Assumes user ports and bus share sys_clk; resets come from the same domain.
//
// Summary of operation
// - 18 kb array, input, output and pipeline registers
// - Single, true dual, pseudo dual, ROM, FIFO modes
// - Widths x1 to x36; true dual up to x18
// - FIFO counters with programmable threshold flags
// - Ninth bit per byte stored as plain port data on x9 and wider; no parity is generated
// - Byte enables on x18 and x36 ports
// - Each port has its own width and depth outside FIFO mode, where port B takes port A's width
// - Bits ordered LSB to MSB, word by word
// - Contents preloadable before user operation
// - ROM is preload plus disabled writes
// - Address and data registered at array input
// - Optional output register adds a cycle
// - Output latch reset clocked, with or without the port's clock enable
// - Per-port local output resets
// - Chip-wide reset clears both output latches
// - Pipeline registers reset like the latches
`timescale 1ns/1ps
`default_nettype none
module embedded_block_ram (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Port A
    input wire logic ce_a,
    input wire logic we_a,
    input wire logic [13:0] addr_a,
    input wire logic [35:0] din_a,
    input wire logic [3:0] byte_en_a,
    output logic [35:0] dout_a,
    // Port B
    input wire logic ce_b,
    input wire logic we_b,
    input wire logic [13:0] addr_b,
    input wire logic [35:0] din_b,
    input wire logic [3:0] byte_en_b,
    output logic [35:0] dout_b,
    // Output resets
    input wire logic port_a_output_reset,
    input wire logic port_b_output_reset,
    input wire logic chip_wide_reset_n,
    // FIFO flags
    output logic fifo_full,
    output logic fifo_almost_full,
    output logic fifo_empty,
    output logic fifo_almost_empty
);
    typedef struct packed {
        ebr_pkg::mode_t mode;
        logic outreg_a, outreg_b;
        logic sync_rst, cfg_done;
        ebr_pkg::width_t width_a, width_b;
        logic [14:0] afull_lvl, aempty_lvl;
        logic [8:0] init_addr;
        logic [31:0] init_lo;
        logic ack;
        logic [31:0] rdat;
        logic rd_a, rd_b;
        logic [5:0] off_a, off_b;
        ebr_pkg::width_t rw_a, rw_b;
        logic [35:0] lat_a, lat_b;
        logic [35:0] dout_a, dout_b;
        logic [13:0] wptr, rptr;
        logic [14:0] count;
        logic full, afull, empty, aempty;
    } state_t;

    state_t state_reg, state_next;

    logic mem_en_a, mem_en_b;
    logic [35:0] mem_wmask_a, mem_wmask_b;
    logic [8:0] mem_addr_a, mem_addr_b;
    logic [35:0] mem_wdata_a, mem_wdata_b;
    logic [35:0] mem_rdata_a, mem_rdata_b;

    // Word index of a port address; narrow widths share one 36-bit word.
    function automatic logic [8:0] word_of(ebr_pkg::width_t w, logic [13:0] a);
        unique case (w)
            ebr_pkg::W_X1: word_of = a[13:5];
            ebr_pkg::W_X2: word_of = a[12:4];
            ebr_pkg::W_X4: word_of = a[11:3];
            ebr_pkg::W_X9: word_of = a[10:2];
            ebr_pkg::W_X18: word_of = a[9:1];
            default: word_of = a[8:0];
        endcase
    endfunction

    // Bit offset inside the word: data bits fill each 9-bit lane from its LSB.
    function automatic logic [5:0] off_of(ebr_pkg::width_t w, logic [13:0] a);
        unique case (w)
            ebr_pkg::W_X1: off_of = 6'(9 * a[4:3] + a[2:0]);
            ebr_pkg::W_X2: off_of = 6'(9 * a[3:2] + 2 * a[1:0]);
            ebr_pkg::W_X4: off_of = 6'(9 * a[2:1] + 4 * a[0]);
            ebr_pkg::W_X9: off_of = 6'(9 * a[1:0]);
            ebr_pkg::W_X18: off_of = 6'(18 * a[0]);
            default: off_of = 6'h00;
        endcase
    endfunction

    // Write mask; byte enables only act on the 18- and 36-bit widths.
    function automatic logic [35:0] mask_of(ebr_pkg::width_t w, logic [3:0] be, logic [5:0] off);
        logic [35:0] lanes, m;
        lanes = 36'h0;
        for (int i = 0; i < ebr_pkg::LANES; i++) begin
            lanes[i*ebr_pkg::LANE_W +: ebr_pkg::LANE_W] = {ebr_pkg::LANE_W{be[i]}};
        end
        unique case (w)
            ebr_pkg::W_X1: m = 36'h000000001;
            ebr_pkg::W_X2: m = 36'h000000003;
            ebr_pkg::W_X4: m = 36'h00000000F;
            ebr_pkg::W_X9: m = 36'h0000001FF;
            ebr_pkg::W_X18: m = {18'h00000, lanes[17:0]};
            default: m = lanes;
        endcase
        mask_of = m << off;
    endfunction

    function automatic logic [14:0] depth_of(ebr_pkg::width_t w);
        unique case (w)
            ebr_pkg::W_X1: depth_of = ebr_pkg::DEPTH_X1;
            ebr_pkg::W_X2: depth_of = ebr_pkg::DEPTH_X2;
            ebr_pkg::W_X4: depth_of = ebr_pkg::DEPTH_X4;
            ebr_pkg::W_X9: depth_of = ebr_pkg::DEPTH_X9;
            ebr_pkg::W_X18: depth_of = ebr_pkg::DEPTH_X18;
            default: depth_of = ebr_pkg::DEPTH_X36;
        endcase
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = old;
    endfunction

    ebr_array u_array (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .en_a(mem_en_a),
        .wmask_a(mem_wmask_a),
        .addr_a(mem_addr_a),
        .wdata_a(mem_wdata_a),
        .rdata_a(mem_rdata_a),
        .en_b(mem_en_b),
        .wmask_b(mem_wmask_b),
        .addr_b(mem_addr_b),
        .wdata_b(mem_wdata_b),
        .rdata_b(mem_rdata_b)
    );

    always_comb begin
        logic req, fifo, push, pop, wr_a, rd_a, wr_b, rd_b, rst_a, rst_b;
        logic [31:0] ctrl_word, wid_word;
        ebr_pkg::width_t wa, wb;
        logic [13:0] pa, pb;
        logic [5:0] oa, ob;
        state_next = state_reg;
        req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        ctrl_word = {25'h0, state_reg.cfg_done, state_reg.sync_rst, state_reg.outreg_b,
                     state_reg.outreg_a, state_reg.mode};
        wid_word = {25'h0, state_reg.width_b, 1'b0, state_reg.width_a};
        mem_en_a = 1'b0;
        mem_en_b = 1'b0;
        mem_wmask_a = 36'h0;
        mem_wmask_b = 36'h0;
        mem_wdata_a = 36'h0;
        mem_wdata_b = 36'h0;

        // Effective widths: true dual port stops at x18, FIFO uses port A's width.
        wa = state_reg.width_a;
        wb = (state_reg.mode == ebr_pkg::MODE_FIFO) ? state_reg.width_a : state_reg.width_b;
        if (state_reg.mode == ebr_pkg::MODE_TRUE_DUAL) begin
            wa = (wa == ebr_pkg::W_X36) ? ebr_pkg::W_X18 : wa;
            wb = (wb == ebr_pkg::W_X36) ? ebr_pkg::W_X18 : wb;
        end

        // Wishbone: one-cycle answer, ack dropped in the following cycle.
        state_next.ack = req;
        state_next.rdat = 32'h0;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                ebr_pkg::REG_CTRL: state_next.rdat = ctrl_word;
                ebr_pkg::REG_WIDTH: state_next.rdat = wid_word;
                ebr_pkg::REG_AFULL: state_next.rdat = {17'h0, state_reg.afull_lvl};
                ebr_pkg::REG_AEMPTY: state_next.rdat = {17'h0, state_reg.aempty_lvl};
                ebr_pkg::REG_STATUS: state_next.rdat = {1'b0, state_reg.count, 12'h0, state_reg.aempty,
                                                        state_reg.empty, state_reg.afull, state_reg.full};
                ebr_pkg::REG_INIT_ADDR: state_next.rdat = {23'h0, state_reg.init_addr};
                ebr_pkg::REG_INIT_LO: state_next.rdat = state_reg.init_lo;
                default: state_next.rdat = 32'h0;
            endcase
        end
        if (req && wb_we_i) begin
            unique case (wb_adr_i)
                ebr_pkg::REG_CTRL: begin
                    ctrl_word = merge(ctrl_word, wb_dat_i, wb_sel_i);
                    state_next.mode = ebr_pkg::mode_t'(ctrl_word[ebr_pkg::CTRL_MODE_LSB +: 3]);
                    state_next.outreg_a = ctrl_word[ebr_pkg::CTRL_OUTREG_A_BIT];
                    state_next.outreg_b = ctrl_word[ebr_pkg::CTRL_OUTREG_B_BIT];
                    state_next.sync_rst = ctrl_word[ebr_pkg::CTRL_SYNC_RST_BIT];
                    state_next.cfg_done = ctrl_word[ebr_pkg::CTRL_CFG_DONE_BIT];
                end
                ebr_pkg::REG_WIDTH: begin
                    wid_word = merge(wid_word, wb_dat_i, wb_sel_i);
                    state_next.width_a = ebr_pkg::width_t'(wid_word[ebr_pkg::WIDTH_A_LSB +: 3]);
                    state_next.width_b = ebr_pkg::width_t'(wid_word[ebr_pkg::WIDTH_B_LSB +: 3]);
                end
                ebr_pkg::REG_AFULL: state_next.afull_lvl = 15'(merge({17'h0, state_reg.afull_lvl},
                                                                     wb_dat_i, wb_sel_i));
                ebr_pkg::REG_AEMPTY: state_next.aempty_lvl = 15'(merge({17'h0, state_reg.aempty_lvl},
                                                                       wb_dat_i, wb_sel_i));
                ebr_pkg::REG_INIT_ADDR: state_next.init_addr = 9'(merge({23'h0, state_reg.init_addr},
                                                                         wb_dat_i, wb_sel_i));
                ebr_pkg::REG_INIT_LO: state_next.init_lo = merge(state_reg.init_lo, wb_dat_i, wb_sel_i);
                ebr_pkg::REG_INIT_HI: begin
                    // Preload only before user operation starts, so no port can collide with it.
                    if (!state_reg.cfg_done) begin
                        mem_en_a = 1'b1;
                        mem_wmask_a = {36{1'b1}};
                        mem_wdata_a = {wb_dat_i[3:0], state_reg.init_lo};
                        state_next.init_addr = state_reg.init_addr + 9'h001;
                    end
                end
                default: state_next.ack = req;
            endcase
        end

        // User port requests; nothing is taken until setup is finished.
        fifo = state_reg.mode == ebr_pkg::MODE_FIFO;
        push = state_reg.cfg_done & fifo & ce_a & we_a & ~state_reg.full;
        pop = state_reg.cfg_done & fifo & ce_b & ~we_b & ~state_reg.empty;
        wr_a = (state_reg.cfg_done & ce_a & we_a & (state_reg.mode == ebr_pkg::MODE_SINGLE
                | state_reg.mode == ebr_pkg::MODE_TRUE_DUAL | state_reg.mode == ebr_pkg::MODE_PSEUDO_DUAL))
               | push;
        rd_a = state_reg.cfg_done & ce_a & ~we_a & (state_reg.mode == ebr_pkg::MODE_SINGLE
               | state_reg.mode == ebr_pkg::MODE_TRUE_DUAL | state_reg.mode == ebr_pkg::MODE_ROM);
        wr_b = state_reg.cfg_done & ce_b & we_b & (state_reg.mode == ebr_pkg::MODE_TRUE_DUAL);
        rd_b = (state_reg.cfg_done & ce_b & ~we_b & (state_reg.mode == ebr_pkg::MODE_TRUE_DUAL
               | state_reg.mode == ebr_pkg::MODE_PSEUDO_DUAL | state_reg.mode == ebr_pkg::MODE_ROM)) | pop;
        pa = fifo ? state_reg.wptr : addr_a;
        pb = fifo ? state_reg.rptr : addr_b;
        oa = off_of(wa, pa);
        ob = off_of(wb, pb);

        // The array's own address and data registers capture the request here.
        mem_addr_a = state_reg.cfg_done ? word_of(wa, pa) : state_reg.init_addr;
        mem_addr_b = word_of(wb, pb);
        if (state_reg.cfg_done) begin
            mem_en_a = wr_a | rd_a;
            mem_wmask_a = wr_a ? mask_of(wa, byte_en_a, oa) : 36'h0;
            mem_wdata_a = din_a << oa;
        end
        mem_en_b = wr_b | rd_b;
        mem_wmask_b = wr_b ? mask_of(wb, byte_en_b, ob) : 36'h0;
        mem_wdata_b = din_b << ob;
        state_next.rd_a = rd_a;
        state_next.rd_b = rd_b;
        state_next.off_a = oa;
        state_next.off_b = ob;
        state_next.rw_a = wa;
        state_next.rw_b = wb;

        // Output latch one cycle after capture; the output register adds one more.
        if (state_reg.rd_a) begin
            state_next.lat_a = (mem_rdata_a >> state_reg.off_a) & mask_of(state_reg.rw_a, 4'hF, 6'h00);
        end
        if (state_reg.rd_b) begin
            state_next.lat_b = (mem_rdata_b >> state_reg.off_b) & mask_of(state_reg.rw_b, 4'hF, 6'h00);
        end
        state_next.dout_a = state_reg.outreg_a ? state_reg.lat_a : state_next.lat_a;
        state_next.dout_b = state_reg.outreg_b ? state_reg.lat_b : state_next.lat_b;

        // Synchronous mode obeys the port's clock enable; asynchronous mode clears at the next edge whatever the enable.
        rst_a = ~chip_wide_reset_n | (port_a_output_reset & (~state_reg.sync_rst | ce_a));
        rst_b = ~chip_wide_reset_n | (port_b_output_reset & (~state_reg.sync_rst | ce_b));
        if (rst_a) begin
            state_next.lat_a = 36'h0;
            state_next.dout_a = 36'h0;
        end
        if (rst_b) begin
            state_next.lat_b = 36'h0;
            state_next.dout_b = 36'h0;
        end

        // FIFO bookkeeping; flags are computed from the next count and registered.
        if (!state_reg.cfg_done || !fifo) begin
            state_next.wptr = 14'h0000;
            state_next.rptr = 14'h0000;
            state_next.count = 15'h0000;
        end else begin
            state_next.wptr = state_reg.wptr + 14'(push);
            state_next.rptr = state_reg.rptr + 14'(pop);
            state_next.count = state_reg.count + 15'(push) - 15'(pop);
        end
        state_next.full = state_next.count == depth_of(wa);
        state_next.empty = state_next.count == 15'h0000;
        state_next.afull = state_next.count >= state_reg.afull_lvl;
        state_next.aempty = state_next.count <= state_reg.aempty_lvl;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
            state_reg.width_a <= ebr_pkg::WIDTH_A_RESET;
            state_reg.width_b <= ebr_pkg::WIDTH_B_RESET;
            state_reg.afull_lvl <= ebr_pkg::AFULL_RESET;
            state_reg.aempty_lvl <= ebr_pkg::AEMPTY_RESET;
            state_reg.empty <= 1'b1;
            state_reg.aempty <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_dat_o = state_reg.rdat;
    assign wb_ack_o = state_reg.ack;
    assign dout_a = state_reg.dout_a;
    assign dout_b = state_reg.dout_b;
    assign fifo_full = state_reg.full;
    assign fifo_almost_full = state_reg.afull;
    assign fifo_empty = state_reg.empty;
    assign fifo_almost_empty = state_reg.aempty;
endmodule // embedded_block_ram
`default_nettype wire

// File: testbench/ebr_assertions.sv
// Checker of the block RAM outputs against their causes.
// Assumes sys_clk and nrst are the only clock and reset.
`timescale 1ns/1ps
`default_nettype none
module ebr_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // User ports
    input wire logic ce_a,
    input wire logic ce_b,
    input wire logic [35:0] dout_a,
    input wire logic [35:0] dout_b,
    input wire logic port_a_output_reset,
    input wire logic port_b_output_reset,
    input wire logic chip_wide_reset_n,
    // Flags
    input wire logic fifo_full,
    input wire logic fifo_almost_full,
    input wire logic fifo_empty,
    input wire logic fifo_almost_empty
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
a_ack: assert property (p_ack) else $error("bus answer wrong");
property p_chip; !chip_wide_reset_n |=> dout_a == 36'h0 && dout_b == 36'h0; endproperty
a_chip: assert property (p_chip) else $error("chip reset missed");
property p_rst_a; port_a_output_reset && ce_a |=> dout_a == 36'h0; endproperty
a_rst_a: assert property (p_rst_a) else $error("port A reset missed");
property p_rst_b; port_b_output_reset && ce_b |=> dout_b == 36'h0; endproperty
a_rst_b: assert property (p_rst_b) else $error("port B reset missed");
property p_hold_a; $changed(dout_a) |-> $past(ce_a) || $past(ce_a, 2) || $past(ce_a, 3) || $past(port_a_output_reset)
    || !$past(chip_wide_reset_n) || $past(wb_ack_o); endproperty
a_hold_a: assert property (p_hold_a) else $error("port A data moved");
property p_hold_b; $changed(dout_b) |-> $past(ce_b) || $past(ce_b, 2) || $past(ce_b, 3) || $past(port_b_output_reset)
    || !$past(chip_wide_reset_n) || $past(wb_ack_o); endproperty
a_hold_b: assert property (p_hold_b) else $error("port B data moved");
property p_empty; fifo_empty |-> fifo_almost_empty && !fifo_full; endproperty
a_empty: assert property (p_empty) else $error("flags disagree");
property p_flag; $changed(fifo_empty) || $changed(fifo_full) |-> $past(ce_a) || $past(ce_b)
    || wb_ack_o || $past(wb_ack_o); endproperty
a_flag: assert property (p_flag) else $error("flag moved alone");
c_full: cover property (fifo_full);
c_afull: cover property (fifo_almost_full && !fifo_full);
c_chip: cover property (!chip_wide_reset_n);
endmodule // ebr_checker
bind embedded_block_ram ebr_checker i_chk (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ce_a(ce_a), .ce_b(ce_b), .dout_a(dout_a), .dout_b(dout_b),
    .port_a_output_reset(port_a_output_reset), .port_b_output_reset(port_b_output_reset),
    .chip_wide_reset_n(chip_wide_reset_n), .fifo_full(fifo_full), .fifo_almost_full(fifo_almost_full),
    .fifo_empty(fifo_empty), .fifo_almost_empty(fifo_almost_empty));
`default_nettype wire

// File: testbench/fabric_user_model.sv
// Fabric user logic driving both RAM ports and their output resets.
// Assumes the bench makes one request at a time through its tasks.
`timescale 1ns/1ps
`default_nettype none
module fabric_user_model (
    // Clock
    input wire logic sys_clk,
    // Port A
    output logic ce_a,
    output logic we_a,
    output logic [13:0] addr_a,
    output logic [35:0] din_a,
    output logic [3:0] byte_en_a,
    // Port B
    output logic ce_b,
    output logic we_b,
    output logic [13:0] addr_b,
    output logic [35:0] din_b,
    output logic [3:0] byte_en_b,
    // Resets
    output logic port_a_output_reset,
    output logic port_b_output_reset,
    output logic chip_wide_reset_n
);
initial begin
    {ce_a, we_a, addr_a, din_a, byte_en_a, port_a_output_reset} = 57'h0;
    {ce_b, we_b, addr_b, din_b, byte_en_b, port_b_output_reset} = 57'h0;
    chip_wide_reset_n = 1'b1;
end
task automatic acc(input logic p, input logic w, input logic [13:0] a, input logic [35:0] d,
    input logic [3:0] be, input logic r);
    @(posedge sys_clk);
    if (p) begin
        {ce_b, we_b, addr_b, din_b, byte_en_b, port_b_output_reset} <= {1'b1, w, a, d, be, r};
    end else begin
        {ce_a, we_a, addr_a, din_a, byte_en_a, port_a_output_reset} <= {1'b1, w, a, d, be, r};
    end
    @(posedge sys_clk);
    // Released lines flip so that a stale address or datum can never pass for a live one.
    {ce_a, ce_b, port_a_output_reset, port_b_output_reset} <= 4'h0;
    {addr_a, din_a, addr_b, din_b} <= ~{addr_a, din_a, addr_b, din_b};
endtask
task automatic resets(input logic [2:0] k);
    @(posedge sys_clk);
    {chip_wide_reset_n, port_b_output_reset, port_a_output_reset} <= k ^ 3'h4;
    @(posedge sys_clk);
    {chip_wide_reset_n, port_b_output_reset, port_a_output_reset} <= 3'h4;
endtask
endmodule // fabric_user_model
`default_nettype wire

// File: testbench/embedded_block_ram_tb.sv
// Self-checking bench of the block RAM: bus setup, then user-port traffic.
// Assumes fabric_user_model drives the user ports and resets.
`timescale 1ns/1ps
`default_nettype none
module embedded_block_ram_tb;
logic sys_clk = 1'b0;
logic nrst = 1'b0;
logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
logic [7:0] wb_adr_i = 8'h00;
logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
logic [3:0] wb_sel_i = 4'h0, byte_en_a, byte_en_b;
logic ce_a, we_a, ce_b, we_b, port_a_output_reset, port_b_output_reset, chip_wide_reset_n;
logic [13:0] addr_a, addr_b;
logic [35:0] din_a, din_b, dout_a, dout_b, q;
logic fifo_full, fifo_almost_full, fifo_empty, fifo_almost_empty;
int n_errors = 0, n_compared = 0, ticks = 0;
localparam logic [35:0] W3 = 36'h589ABCDEF;
localparam logic [35:0] W7 = 36'h123456789;
localparam logic [7:0] RA [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40};
localparam logic [35:0] RV [5] = '{36'h0, 36'h55, 36'h1F8, 36'h8, 36'h0};
embedded_block_ram i_dut (.*);
fabric_user_model i_user (.*);
initial begin
    forever #12.5 sys_clk = ~sys_clk;
end
task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
        n_errors++;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hF};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = {4'h0, wb_dat_o};
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
endtask
task automatic rd(input logic p, input logic [13:0] a, input int lat);
    i_user.acc(p, 1'b0, a, 36'h0, 4'h0, 1'b0);
    repeat (lat) @(posedge sys_clk);
    #1 q = p ? dout_b : dout_a;
endtask
task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask
// Full run is near 2,700 cycles; the ceiling leaves ample margin.
always @(posedge sys_clk) begin
    ticks++;
    if (ticks == 6000) begin
        n_errors++;
        wrap_up();
    end
end
initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (RA[i]) begin
        wb(1'b0, RA[i], 32'h0);
        chk(q, RV[i]);
    end
    $display("registers done");
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b1, 8'h18, 32'h89ABCDEF);
    wb(1'b1, 8'h1C, 32'h5);
    wb(1'b1, 8'h00, 32'h40);
    rd(1'b0, 14'h3, 1);
    chk(q, W3);
    i_user.acc(1'b0, 1'b1, 14'h5, 36'h0, 4'hF, 1'b0);
    i_user.acc(1'b0, 1'b1, 14'h5, 36'hFFFFFFFFF, 4'h5, 1'b0);
    rd(1'b0, 14'h5, 1);
    chk(q, 36'h007FC01FF);
    $display("preload and byte lanes done");
    wb(1'b1, 8'h00, 32'h48);
    rd(1'b0, 14'h5, 2);
    chk(q, 36'h007FC01FF);
    i_user.acc(1'b0, 1'b0, 14'h3, 36'h0, 4'h0, 1'b0);
    @(posedge sys_clk);
    #1 chk(dout_a, 36'h007FC01FF);
    @(posedge sys_clk);
    #1 chk(dout_a, W3);
    $display("output register done");
    wb(1'b1, 8'h00, 32'h02);
    wb(1'b1, 8'h04, 32'h35);
    wb(1'b1, 8'h00, 32'h42);
    i_user.acc(1'b0, 1'b1, 14'h7, W7, 4'hF, 1'b0);
    for (int i = 0; i < 4; i++) begin
        rd(1'b1, 14'(28 + i), 1);
        chk(q, (W7 >> (9 * i)) & 36'h1FF);
    end
    wb(1'b1, 8'h00, 32'h41);
    i_user.acc(1'b1, 1'b1, 14'h1C, 36'h0AA, 4'hF, 1'b0);
    rd(1'b0, 14'hE, 1);
    chk(q, {18'h0, W7[17:9], 9'h0AA});
    $display("mixed widths done");
    wb(1'b1, 8'h00, 32'h03);
    wb(1'b1, 8'h04, 32'h55);
    wb(1'b1, 8'h00, 32'h43);
    i_user.acc(1'b0, 1'b1, 14'h3, 36'h0, 4'hF, 1'b0);
    rd(1'b0, 14'h3, 1);
    chk(q, W3);
    rd(1'b1, 14'h3, 1);
    chk(q, W3);
    i_user.acc(1'b0, 1'b0, 14'h3, 36'h0, 4'h0, 1'b1);
    #1 chk(dout_a, 36'h0);
    chk(dout_b, W3);
    i_user.acc(1'b1, 1'b0, 14'h3, 36'h0, 4'h0, 1'b1);
    #1 chk(dout_b, 36'h0);
    rd(1'b0, 14'h3, 1);
    i_user.resets(3'h4);
    #1 chk(dout_a, 36'h0);
    wb(1'b1, 8'h00, 32'h63);
    rd(1'b0, 14'h3, 1);
    i_user.resets(3'h1);
    #1 chk(dout_a, W3);
    $display("rom and resets done");
    wb(1'b1, 8'h00, 32'h04);
    wb(1'b1, 8'h08, 32'h2);
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h00, 32'h44);
    for (int i = 0; i < 512; i++) begin
        i_user.acc(1'b0, 1'b1, 14'h0, 36'(i), 4'hF, 1'b0);
        #1 if (i < 2) chk(36'({fifo_empty, fifo_almost_empty, fifo_almost_full}), i ? 36'h1 : 36'h2);
    end
    chk(36'(fifo_full), 36'h1);
    i_user.acc(1'b0, 1'b1, 14'h0, 36'hABC, 4'hF, 1'b0);
    for (int i = 0; i < 512; i++) begin
        rd(1'b1, 14'h0, 1);
        chk(q, 36'(i));
    end
    chk(36'({fifo_empty, fifo_full}), 36'h2);
    $display("fifo done");
    wrap_up();
end
endmodule // embedded_block_ram_tb
`default_nettype wire
